/* File: src/vsac_pkg.sv */
// vsac_pkg: constants, addresses and types for the vme slave access configuration block
// assumes: one 20 MHz board clock; local bus addresses are full 32-bit byte addresses
package vsac_pkg;
   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int VSAC_AW = 32;
   localparam int VSAC_DW = 8;
   localparam int VSAC_AMW = 6;
   localparam int VSAC_NBASE = 10;   // base bits 31..22
   localparam int VSAC_BASE_LSB = 22;
   localparam int VSAC_A24_MSB = 23;  // top bit of a 24-bit address

   // ----------------------------------------------------------------------
   // local write locations
   // ----------------------------------------------------------------------
   localparam logic [31:0] VSAC_PRIMARY_MODE_ADDR = 32'hFE380003;
   localparam logic [31:0] VSAC_EXT_MODE_ADDR = 32'hFE384003;
   localparam logic [31:0] VSAC_SLV_CTRL_BASE = 32'hFE388000;
   localparam logic [31:0] VSAC_EXT_CTRL_BASE = 32'hFE3A0000;
   localparam logic [31:0] VSAC_SET_A32_ADDR = 32'hFE388000;
   localparam logic [31:0] VSAC_SET_A24_ADDR = 32'hFE388001;
   localparam logic [31:0] VSAC_SUP_ON_ADDR = 32'hFE388002;
   localparam logic [31:0] VSAC_SUP_OFF_ADDR = 32'hFE388003;

   // clear location per base bit, index 0 is bit 22, index 9 is bit 31
   localparam logic [31:0] VSAC_BASE_CLR_ADDR [VSAC_NBASE] = '{
      32'hFE388004, 32'hFE388006, 32'hFE388008, 32'hFE38800A, 32'hFE38800C,
      32'hFE3A0008, 32'hFE3A000A, 32'hFE3A000C, 32'hFE3A000E, 32'hFE38800E};
   // set location is the clear location plus one
   localparam logic [31:0] VSAC_BASE_SET_STEP = 32'h00000001;

   // ----------------------------------------------------------------------
   // data codes and reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] VSAC_PROTECT_ON_CODE = 8'h0D;
   localparam logic [7:0] VSAC_PROTECT_OFF_CODE = 8'h05;
   localparam logic [7:0] VSAC_SLAVE_EN_CODE = 8'h0F;
   localparam logic [7:0] VSAC_SLAVE_DIS_CODE = 8'h07;
   localparam logic VSAC_RST_A24 = 1'b0;
   localparam logic VSAC_RST_PROTECT = 1'b0;
   localparam logic VSAC_RST_SUP_ONLY = 1'b1;
   localparam logic VSAC_RST_ENABLE = 1'b0;
   localparam logic [VSAC_NBASE-1:0] VSAC_RST_BASE = 10'h000;

   // ----------------------------------------------------------------------
   // address modifier codes (low two bits select program/data/block)
   // ----------------------------------------------------------------------
   localparam logic [3:0] VSAC_AM_A32_SUP = 4'h3;   // 0x0C..0x0F
   localparam logic [3:0] VSAC_AM_A32_USR = 4'h2;   // 0x08..0x0B
   localparam logic [3:0] VSAC_AM_A24_SUP = 4'hF;   // 0x3C..0x3F
   localparam logic [3:0] VSAC_AM_A24_USR = 4'hE;   // 0x38..0x3B

   // ----------------------------------------------------------------------
   // slave access sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      VSAC_IDLE = 3'b001,
      VSAC_BUSY = 3'b010,
      VSAC_DONE = 3'b100
   } vsac_state_t;
endpackage : vsac_pkg

/* File: src/vsac_cfg_if.sv */
// vsac_cfg_if: carries slave configuration and one access to the judge and its verdict back
// assumes: both ends run on the same board clock
`timescale 1ns/10ps
interface vsac_cfg_if;
   import vsac_pkg::*;
   logic enable;
   logic a24;
   logic protect;
   logic sup_only;
   logic [VSAC_NBASE-1:0] base;
   logic [VSAC_AMW-1:0] am;
   logic [VSAC_AW-1:0] addr;
   logic write;
   logic hit;
   logic rd_ok;
   logic wr_ok;
   logic refused;

   modport ctl (
      output enable, a24, protect, sup_only, base, am, addr, write,
      input hit, rd_ok, wr_ok, refused
   );
   modport judge (
      input enable, a24, protect, sup_only, base, am, addr, write,
      output hit, rd_ok, wr_ok, refused
   );
endinterface : vsac_cfg_if

/* File: src/vsac_judge.sv */
// vsac_judge: combinational verdict on one slave access from the current configuration
// assumes: address and modifier are stable, already synchronised values
`timescale 1ns/10ps
module vsac_judge (
   vsac_cfg_if.judge cfg
);
   import vsac_pkg::*;

   // ----------------------------------------------------------------------
   // modifier classification
   // ----------------------------------------------------------------------
   // returns {recognised, supervisory} for the selected address mode
   function automatic logic [1:0] vsac_am_class(input logic [VSAC_AMW-1:0] am,
                                                input logic a24);
      logic [3:0] grp;
      grp = am[5:2];
      vsac_am_class = 2'b00;
      if (a24) begin
         if (grp == VSAC_AM_A24_SUP) vsac_am_class = 2'b11;
         else if (grp == VSAC_AM_A24_USR) vsac_am_class = 2'b10;
      end else begin
         if (grp == VSAC_AM_A32_SUP) vsac_am_class = 2'b11;
         else if (grp == VSAC_AM_A32_USR) vsac_am_class = 2'b10;
      end
   endfunction : vsac_am_class

   logic [1:0] cls;
   logic win;

   // short (16-bit) modifiers never classify, so they never hit
   assign cls = vsac_am_class(cfg.am, cfg.a24);

   // window match: a32 compares bits 31..22, a24 only bits 23..22
   always_comb begin
      if (cfg.a24) begin
         win = (cfg.addr[VSAC_A24_MSB:VSAC_BASE_LSB] ==
                cfg.base[VSAC_A24_MSB-VSAC_BASE_LSB:0]);
      end else begin
         win = (cfg.addr[VSAC_AW-1:VSAC_BASE_LSB] == cfg.base);
      end
   end

   // ----------------------------------------------------------------------
   // verdict
   // ----------------------------------------------------------------------
   assign cfg.hit = cfg.enable & cls[1] & win;
   assign cfg.rd_ok = cfg.hit & ~cfg.write;
   // protect overrides supervisor-only, which then needs a supervisory code
   assign cfg.wr_ok = cfg.hit & cfg.write & ~cfg.protect &
                      (~cfg.sup_only | cls[0]);
   assign cfg.refused = cfg.hit & cfg.write & ~cfg.wr_ok;
endmodule : vsac_judge

/* File: src/vsac_top.sv */
// vsac_top: configuration registers and write protection for the vme slave ram port
// assumes: local writes are one-cycle strobes on the board clock; vme pins are asynchronous
//
// Summary of operation
// - slave decodes 32-bit or 24-bit addresses, chosen by a mode bit
// - accesses using 16-bit short addressing never get a slave response
// - reset gives 32-bit mode; any write to the a24 location selects 24-bit
// - reset or a write to the a32 location returns to 32-bit mode
// - an enabled slave lets every master read ram at any protection level
// - three write levels; full protect refuses every external write
// - protect overrides supervisor-only, which counts only while protect is off
// - primary mode byte 0D turns protect on, 05 turns it off
// - protect is off after reset; reset or code 05 clears it
// - privilege of each access comes from its address modifier code
// - protect off, supervisor-only on: supervisory writes pass, user writes blocked
// - protect off, supervisor-only off: every slave write passes
// - supervisor-only on after reset; one location clears it, another sets it
// - each base bit has its own clear location and set location
// - a32/a24, supervisor-only and base locations act on address only, data ignored; the two mode bytes use data
// - all base bits are zero after reset
// - slave disabled after reset, silent until enabled, still configurable
`timescale 1ns/10ps
module vsac_top (
   clk,
   rst,
   loc_wr_stb,
   loc_addr,
   loc_data,
   vme_as_n,
   vme_write_n,
   vme_am,
   vme_addr,
   slave_ack,
   ram_rd_en,
   ram_wr_en,
   ram_addr,
   wr_refused,
   cfg_a24,
   cfg_protect,
   cfg_sup_only,
   cfg_enable,
   cfg_base
);
   import vsac_pkg::*;

   input wire logic clk;
   input wire logic rst;
   input wire logic loc_wr_stb;
   input wire logic [vsac_pkg::VSAC_AW-1:0] loc_addr;
   input wire logic [vsac_pkg::VSAC_DW-1:0] loc_data;
   input wire logic vme_as_n;
   input wire logic vme_write_n;
   input wire logic [vsac_pkg::VSAC_AMW-1:0] vme_am;
   input wire logic [vsac_pkg::VSAC_AW-1:0] vme_addr;
   output logic slave_ack;
   output logic ram_rd_en;
   output logic ram_wr_en;
   output logic [vsac_pkg::VSAC_AW-1:0] ram_addr;
   output logic wr_refused;
   output logic cfg_a24;
   output logic cfg_protect;
   output logic cfg_sup_only;
   output logic cfg_enable;
   output logic [vsac_pkg::VSAC_NBASE-1:0] cfg_base;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic a24_r;
   logic protect_r;
   logic sup_only_r;
   logic enable_r;
   logic [VSAC_NBASE-1:0] base_r;

   logic as_n_m_r;
   logic as_n_s_r;
   logic write_n_m_r;
   logic write_n_s_r;
   logic [VSAC_AMW-1:0] am_m_r;
   logic [VSAC_AMW-1:0] am_s_r;
   logic [VSAC_AW-1:0] addr_m_r;
   logic [VSAC_AW-1:0] addr_s_r;

   vsac_state_t state_r;
   vsac_state_t state_nxt;
   logic ack_r;
   logic rd_en_r;
   logic wr_en_r;
   logic refused_r;
   logic [VSAC_AW-1:0] ram_addr_r;

   // local write decode helper, used for every configuration location
   function automatic logic vsac_hit(input logic stb, input logic [VSAC_AW-1:0] a,
                                     input logic [VSAC_AW-1:0] loc);
      vsac_hit = stb & (a == loc);
   endfunction : vsac_hit

   // ----------------------------------------------------------------------
   // address mode
   // ----------------------------------------------------------------------
   // data lines are not looked at for these locations
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a24_r <= VSAC_RST_A24;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_SET_A24_ADDR)) begin
         a24_r <= 1'b1;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_SET_A32_ADDR)) begin
         a24_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // memory protect (primary mode byte)
   // ----------------------------------------------------------------------
   // other byte values leave protect unchanged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         protect_r <= VSAC_RST_PROTECT;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_PRIMARY_MODE_ADDR)) begin
         if (loc_data == VSAC_PROTECT_ON_CODE) begin
            protect_r <= 1'b1;
         end else if (loc_data == VSAC_PROTECT_OFF_CODE) begin
            protect_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // supervisor-only
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sup_only_r <= VSAC_RST_SUP_ONLY;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_SUP_OFF_ADDR)) begin
         sup_only_r <= 1'b0;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_SUP_ON_ADDR)) begin
         sup_only_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // slave master switch (extended mode byte)
   // ----------------------------------------------------------------------
   // configuration writes above stay live while the slave is off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_r <= VSAC_RST_ENABLE;
      end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_EXT_MODE_ADDR)) begin
         if (loc_data == VSAC_SLAVE_EN_CODE) begin
            enable_r <= 1'b1;
         end else if (loc_data == VSAC_SLAVE_DIS_CODE) begin
            enable_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // window base bits
   // ----------------------------------------------------------------------
   // one clear and one set location per bit, address decode only
   generate
      for (genvar i = 0; i < VSAC_NBASE; i++) begin : g_base
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               base_r[i] <= VSAC_RST_BASE[i];
            end else if (vsac_hit(loc_wr_stb, loc_addr, VSAC_BASE_CLR_ADDR[i])) begin
               base_r[i] <= 1'b0;
            end else if (vsac_hit(loc_wr_stb, loc_addr,
                                  VSAC_BASE_CLR_ADDR[i] + VSAC_BASE_SET_STEP)) begin
               base_r[i] <= 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // vme pin synchronisers
   // ----------------------------------------------------------------------
   // two stages; only the second stage feeds logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         as_n_m_r <= 1'b1;
         as_n_s_r <= 1'b1;
         write_n_m_r <= 1'b1;
         write_n_s_r <= 1'b1;
      end else begin
         as_n_m_r <= vme_as_n;
         as_n_s_r <= as_n_m_r;
         write_n_m_r <= vme_write_n;
         write_n_s_r <= write_n_m_r;
      end
   end

   // address and modifier follow the same two stages as the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         am_m_r <= '0;
         am_s_r <= '0;
         addr_m_r <= '0;
         addr_s_r <= '0;
      end else begin
         am_m_r <= vme_am;
         am_s_r <= am_m_r;
         addr_m_r <= vme_addr;
         addr_s_r <= addr_m_r;
      end
   end

   // ----------------------------------------------------------------------
   // judge
   // ----------------------------------------------------------------------
   vsac_cfg_if cfg_bus ();

   // configuration and the synchronised access go to the judge
   assign cfg_bus.enable = enable_r;
   assign cfg_bus.a24 = a24_r;
   assign cfg_bus.protect = protect_r;
   assign cfg_bus.sup_only = sup_only_r;
   assign cfg_bus.base = base_r;
   assign cfg_bus.am = am_s_r;
   assign cfg_bus.addr = addr_s_r;
   assign cfg_bus.write = ~write_n_s_r;

   vsac_judge u_judge (
      .cfg(cfg_bus)
   );

   // ----------------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------------
   // idle waits for strobe; busy holds verdict; done waits for strobe release
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         VSAC_IDLE: begin
            if (!as_n_s_r) state_nxt = VSAC_BUSY;
         end
         VSAC_BUSY: begin
            state_nxt = VSAC_DONE;
         end
         VSAC_DONE: begin
            if (as_n_s_r) state_nxt = VSAC_IDLE;
         end
         default: begin
            state_nxt = VSAC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= VSAC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // verdict taken once per strobe; ram enables are one-cycle pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_en_r <= 1'b0;
         wr_en_r <= 1'b0;
         ram_addr_r <= '0;
      end else begin
         rd_en_r <= 1'b0;
         wr_en_r <= 1'b0;
         if (state_r == VSAC_IDLE && !as_n_s_r) begin
            rd_en_r <= cfg_bus.rd_ok;
            wr_en_r <= cfg_bus.wr_ok;
            ram_addr_r <= addr_s_r;
         end
      end
   end

   // acknowledge and refusal flag stand until the strobe goes away
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
         refused_r <= 1'b0;
      end else if (as_n_s_r) begin
         ack_r <= 1'b0;
         refused_r <= 1'b0;
      end else if (state_r == VSAC_IDLE) begin
         ack_r <= cfg_bus.rd_ok | cfg_bus.wr_ok;
         refused_r <= cfg_bus.refused;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign slave_ack = ack_r;
   assign ram_rd_en = rd_en_r;
   assign ram_wr_en = wr_en_r;
   assign ram_addr = ram_addr_r;
   assign wr_refused = refused_r;
   assign cfg_a24 = a24_r;
   assign cfg_protect = protect_r;
   assign cfg_sup_only = sup_only_r;
   assign cfg_enable = enable_r;
   assign cfg_base = base_r;
endmodule : vsac_top

/* File: test/vsac_monitor.sv */
// vsac_monitor: port-level checks of the slave access configuration block
// assumes: one clock clk, asynchronous active-high rst, bound into vsac_top
`timescale 1ns/10ps
module vsac_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic loc_wr_stb,
   input wire logic [vsac_pkg::VSAC_AW-1:0] loc_addr,
   input wire logic [vsac_pkg::VSAC_DW-1:0] loc_data,
   input wire logic vme_as_n,
   input wire logic vme_write_n,
   input wire logic [vsac_pkg::VSAC_AMW-1:0] vme_am,
   input wire logic [vsac_pkg::VSAC_AW-1:0] vme_addr,
   input wire logic slave_ack,
   input wire logic ram_rd_en,
   input wire logic ram_wr_en,
   input wire logic [vsac_pkg::VSAC_AW-1:0] ram_addr,
   input wire logic wr_refused,
   input wire logic cfg_a24,
   input wire logic cfg_protect,
   input wire logic cfg_sup_only,
   input wire logic cfg_enable,
   input wire logic [vsac_pkg::VSAC_NBASE-1:0] cfg_base
);
   import vsac_pkg::*;
   logic ram_go;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // any ram strobe, read or write
   assign ram_go = ram_rd_en | ram_wr_en;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_strobe_needs_en: assert property (ram_go |-> cfg_enable && !$past(vme_as_n, 2))
      else $error("ram strobe while disabled or without address strobe");
   a_pulse_one_cycle: assert property (ram_go |=> !ram_go)
      else $error("ram strobe longer than one cycle");
   a_read_dir: assert property (ram_rd_en |-> $past(vme_write_n, 2) && !ram_wr_en)
      else $error("read strobe for a write cycle");
   a_mode_am_class: assert property (
      ram_go |-> $past(vme_am[5:3], 2) == (cfg_a24 ? 3'h7 : 3'h1))
      else $error("address modifier does not match decode mode");
   a_protect_no_wr: assert property (cfg_protect && $past(cfg_protect) |-> !ram_wr_en)
      else $error("write passed under full protect");
   a_user_wr_block: assert property (
      ram_wr_en && cfg_sup_only |-> $past(vme_am[2], 2))
      else $error("user write passed under supervisor-only");
   a_window_hit: assert property (
      ram_go |-> (cfg_a24 ? ram_addr[23:22] == cfg_base[1:0] : ram_addr[31:22] == cfg_base))
      else $error("access outside the slave window");
   a_refuse_quiet: assert property (wr_refused |-> !ram_wr_en && !slave_ack)
      else $error("refused write still reached ram");
   a_a24_select: assert property (
      loc_wr_stb && loc_addr == VSAC_SET_A24_ADDR |=> cfg_a24)
      else $error("a24 location did not select 24-bit mode");
   a_protect_code: assert property (
      loc_wr_stb && loc_addr == VSAC_PRIMARY_MODE_ADDR && loc_data == VSAC_PROTECT_ON_CODE
      |=> cfg_protect)
      else $error("protect code did not set protection");
   a_sup_off: assert property (
      loc_wr_stb && loc_addr == VSAC_SUP_OFF_ADDR |=> !cfg_sup_only)
      else $error("supervisor-only not cleared");
   c_read: cover property (ram_rd_en && cfg_protect);
   c_refused: cover property ($rose(wr_refused));
   c_a24_write: cover property (ram_wr_en && cfg_a24);
endmodule : vsac_monitor
bind vsac_top vsac_monitor i_mon (.clk(clk), .rst(rst), .loc_wr_stb(loc_wr_stb),
   .loc_addr(loc_addr), .loc_data(loc_data), .vme_as_n(vme_as_n), .vme_write_n(vme_write_n),
   .vme_am(vme_am), .vme_addr(vme_addr), .slave_ack(slave_ack), .ram_rd_en(ram_rd_en),
   .ram_wr_en(ram_wr_en), .ram_addr(ram_addr), .wr_refused(wr_refused), .cfg_a24(cfg_a24),
   .cfg_protect(cfg_protect), .cfg_sup_only(cfg_sup_only), .cfg_enable(cfg_enable),
   .cfg_base(cfg_base));

/* File: test/vsac_vme_master.sv */
// vsac_vme_master: external vme master that runs one slave cycle per call
// assumes: driven on the falling edge of the board clock
`timescale 1ns/10ps
module vsac_vme_master (
   input wire logic clk,
   output logic vme_as_n,
   output logic vme_write_n,
   output logic [vsac_pkg::VSAC_AMW-1:0] vme_am,
   output logic [vsac_pkg::VSAC_AW-1:0] vme_addr,
   input wire logic ram_rd_en,
   input wire logic ram_wr_en,
   input wire logic slave_ack,
   input wire logic wr_refused,
   input wire logic [vsac_pkg::VSAC_AW-1:0] ram_addr
);
   import vsac_pkg::*;
   // idle bus with strobe high
   initial begin
      vme_as_n = 1'b1;
      vme_write_n = 1'b1;
      vme_am = 6'h00;
      vme_addr = 32'h00000000;
   end
   // one cycle: seen is {read, write, ack, refused}; lines inverted once released
   task automatic run(input logic w, input logic [5:0] m, input logic [31:0] a,
      output logic [3:0] seen, output logic [31:0] got);
      seen = 4'h0;
      got = ~a;
      @(negedge clk);
      vme_write_n = ~w;
      vme_am = m;
      vme_addr = a;
      vme_as_n = 1'b0;
      repeat (6) begin
         @(negedge clk);
         if (ram_rd_en === 1'b1) seen[3] = 1'b1;
         if (ram_wr_en === 1'b1) seen[2] = 1'b1;
         if (ram_rd_en === 1'b1 || ram_wr_en === 1'b1) got = ram_addr;
      end
      seen[1] = slave_ack;
      seen[0] = wr_refused;
      vme_as_n = 1'b1;
      vme_write_n = w;
      vme_am = ~m;
      vme_addr = ~a;
      repeat (4) @(negedge clk);
   endtask : run
endmodule : vsac_vme_master

/* File: test/tb_top.sv */
// tb_top: self-checking bench for vsac_top with a behavioural vme master
// assumes: 20 MHz clock, local writes and vme pins driven on the falling edge
`timescale 1ns/10ps
module tb_top;
   import vsac_pkg::*;
   typedef struct packed {
      logic [7:0] prot;
      logic sup;
      logic a24;
      logic wr;
      logic [5:0] am;
      logic [2:0] exp;
   } vsac_row_t;
   localparam logic [9:0] BASE_PAT = 10'h1EB;
   localparam logic [31:0] WIN32 = 32'h7AC01234;
   localparam logic [31:0] WIN24 = 32'h00C01234;
   logic clk, rst, loc_wr_stb, vme_as_n, vme_write_n, slave_ack, ram_rd_en, ram_wr_en;
   logic wr_refused, cfg_a24, cfg_protect, cfg_sup_only, cfg_enable;
   logic [31:0] loc_addr, vme_addr, ram_addr;
   logic [7:0] loc_data;
   logic [5:0] vme_am;
   logic [9:0] cfg_base;
   int n_fail = 0;
   int num_checks = 0;
   // rows: protect byte, sup-only, a24, write, modifier, expected {read, write, refused}
   vsac_row_t rows [10] = '{
      '{8'h05, 1'b1, 1'b0, 1'b0, 6'h0D, 3'h4},
      '{8'h0D, 1'b1, 1'b0, 1'b0, 6'h09, 3'h4},
      '{8'h0D, 1'b0, 1'b0, 1'b1, 6'h0D, 3'h1},
      '{8'h05, 1'b1, 1'b0, 1'b1, 6'h0D, 3'h2},
      '{8'h05, 1'b1, 1'b0, 1'b1, 6'h09, 3'h1},
      '{8'h05, 1'b0, 1'b0, 1'b1, 6'h09, 3'h2},
      '{8'h05, 1'b0, 1'b1, 1'b1, 6'h3D, 3'h2},
      '{8'h05, 1'b1, 1'b1, 1'b1, 6'h39, 3'h1},
      '{8'h05, 1'b0, 1'b0, 1'b1, 6'h2D, 3'h0},
      '{8'h05, 1'b0, 1'b1, 1'b1, 6'h0D, 3'h0}};
   vsac_top i_dut (.clk(clk), .rst(rst), .loc_wr_stb(loc_wr_stb), .loc_addr(loc_addr),
      .loc_data(loc_data), .vme_as_n(vme_as_n), .vme_write_n(vme_write_n), .vme_am(vme_am),
      .vme_addr(vme_addr), .slave_ack(slave_ack), .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en),
      .ram_addr(ram_addr), .wr_refused(wr_refused), .cfg_a24(cfg_a24), .cfg_protect(cfg_protect),
      .cfg_sup_only(cfg_sup_only), .cfg_enable(cfg_enable), .cfg_base(cfg_base));
   vsac_vme_master i_vme (.clk(clk), .vme_as_n(vme_as_n), .vme_write_n(vme_write_n),
      .vme_am(vme_am), .vme_addr(vme_addr), .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en),
      .slave_ack(slave_ack), .wr_refused(wr_refused), .ram_addr(ram_addr));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // one local byte write, strobe high for one cycle
   task automatic lw(input logic [31:0] a, input logic [7:0] d);
      @(negedge clk);
      loc_wr_stb = 1'b1;
      loc_addr = a;
      loc_data = d;
      @(negedge clk);
      loc_wr_stb = 1'b0;
   endtask : lw
   // one vme cycle compared with {read, write, ack, refused}
   task automatic acc(input logic w, input logic [5:0] m, input logic [31:0] a,
      input logic [3:0] exp);
      logic [3:0] seen;
      logic [31:0] got;
      i_vme.run(w, m, a, seen, got);
      chk("vme verdict", {28'h0, exp}, {28'h0, seen});
      if (exp[3:2] != 2'h0) chk("ram_addr", a, got);
   endtask : acc
   // enable, a24, protect, sup-only, base
   task automatic chk_cfg(input logic [13:0] exp);
      logic [31:0] seen;
      seen = {18'h0, cfg_enable, cfg_a24, cfg_protect, cfg_sup_only, cfg_base};
      chk("cfg", {18'h0, exp}, seen);
   endtask : chk_cfg
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #250000;
      n_fail++;
      $display("watchdog expired");
      give_verdict();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      loc_wr_stb = 1'b0;
      loc_addr = 32'h00000000;
      loc_data = 8'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk_cfg(14'h0400);
      acc(1'b0, 6'h0D, 32'h00001234, 4'h0);
      for (int i = 0; i < VSAC_NBASE; i++) begin
         lw(VSAC_BASE_CLR_ADDR[i] + (BASE_PAT[i] ? VSAC_BASE_SET_STEP : '0), 8'hA5);
      end
      chk("cfg_base", {22'h0, BASE_PAT}, {22'h0, cfg_base});
      lw(VSAC_EXT_MODE_ADDR, VSAC_SLAVE_EN_CODE);
      chk("cfg_enable", 32'h1, {31'h0, cfg_enable});
      $display("test reset_and_setup done");
      foreach (rows[i]) begin
         lw(VSAC_PRIMARY_MODE_ADDR, rows[i].prot);
         lw(rows[i].sup ? VSAC_SUP_ON_ADDR : VSAC_SUP_OFF_ADDR, 8'h5A);
         lw(rows[i].a24 ? VSAC_SET_A24_ADDR : VSAC_SET_A32_ADDR, 8'hC3);
         chk("cfg_a24", {31'h0, rows[i].a24}, {31'h0, cfg_a24});
         acc(rows[i].wr, rows[i].am, rows[i].a24 ? WIN24 : WIN32,
            {rows[i].exp[2:1], |rows[i].exp[2:1], rows[i].exp[0]});
      end
      $display("test access_table done");
      lw(VSAC_PRIMARY_MODE_ADDR, VSAC_PROTECT_ON_CODE);
      lw(VSAC_PRIMARY_MODE_ADDR, 8'h33);
      chk("cfg_protect", 32'h1, {31'h0, cfg_protect});
      lw(VSAC_PRIMARY_MODE_ADDR, VSAC_PROTECT_OFF_CODE);
      chk("cfg_protect", 32'h0, {31'h0, cfg_protect});
      $display("test protect_codes done");
      lw(VSAC_SET_A32_ADDR, 8'h00);
      lw(VSAC_BASE_CLR_ADDR[0], 8'hFF);
      chk("cfg_base", 32'h1EA, {22'h0, cfg_base});
      acc(1'b0, 6'h0D, WIN32, 4'h0);
      acc(1'b0, 6'h0D, 32'h7A801234, 4'hA);
      lw(VSAC_EXT_MODE_ADDR, VSAC_SLAVE_DIS_CODE);
      acc(1'b0, 6'h0D, 32'h7A801234, 4'h0);
      $display("test window_and_disable done");
      lw(VSAC_SUP_OFF_ADDR, 8'h00);
      lw(VSAC_SET_A24_ADDR, 8'h00);
      lw(VSAC_PRIMARY_MODE_ADDR, VSAC_PROTECT_ON_CODE);
      lw(VSAC_EXT_MODE_ADDR, VSAC_SLAVE_EN_CODE);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk_cfg(14'h0400);
      $display("test mid_run_reset done");
      give_verdict();
   end
endmodule : tb_top
